// *** hw/pmg_gain_filter.sv ***
/*
 pmg_gain_filter: passes a change of its input once it has held for a
 programmable number of cycles.
 Assumes the input is synchronous to clk.
*/
`timescale 1ns/10ps
module pmg_gain_filter (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic raw,
    input wire logic [7:0] hold_cycles,
    output logic filtered
);

    logic [7:0] count_q;

    // ==========================================================
    // hysteresis counter
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_q <= 8'h00;
            filtered <= 1'b0;
        end else if (clk_en) begin
            if (clear) begin
                count_q <= 8'h00;
                filtered <= 1'b0;
            end else if (raw == filtered) begin
                count_q <= 8'h00;
            end else if (count_q >= hold_cycles) begin
                count_q <= 8'h00;
                filtered <= raw;
            end else begin
                count_q <= count_q + 8'h01;
            end
        end
    end

endmodule : pmg_gain_filter

// *** hw/pmg_pkg.sv ***
/*
 pmg_pkg: register map, fields, reset values, counts and mode type of the
 power mode and pump gain controller.
 Assumes a 100 MHz internal clock.
*/
package pmg_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_DEVICE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TEMP_COMP = 8'h01;
    localparam logic [7:0] ADDR_GAIN_HYST = 8'h02;
    localparam logic [7:0] ADDR_GENERAL_CONFIG = 8'h36;
    localparam logic [7:0] ADDR_STATUS = 8'h3a;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h3d;
    localparam logic [7:0] SOFT_RESET_VALUE = 8'hff;

    // ==========================================================
    // field positions
    localparam int DEVICE_ON_BIT = 6;
    localparam int GAIN_SEL_LSB = 3;
    localparam int PWM_PS_BIT = 5;
    localparam int TC_MODE_BIT = 5;

    // ==========================================================
    // reset values
    localparam logic [7:0] DEVICE_CTRL_RESET = 8'h00;
    localparam logic [7:0] TEMP_COMP_RESET = 8'h00;
    localparam logic [7:0] GAIN_HYST_RESET = 8'h10;
    localparam logic [7:0] GENERAL_CONFIG_RESET = 8'h00;

    // ==========================================================
    // gain select encodings and pump gain outputs
    localparam logic [1:0] GSEL_OFF = 2'h0;
    localparam logic [1:0] GSEL_BYPASS = 2'h1;
    localparam logic [1:0] GSEL_BOOST = 2'h2;
    localparam logic [1:0] GSEL_AUTO = 2'h3;
    localparam logic [1:0] PUMP_OFF = 2'h0;
    localparam logic [1:0] PUMP_1X = 2'h1;
    localparam logic [1:0] PUMP_1P5X = 2'h2;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int STARTUP_TIME_US = 500;
    localparam int IDLE_FALLBACK_TIME_MS = 50;
    localparam int STARTUP_CYCLES = (STARTUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_FALLBACK_CYCLES = (IDLE_FALLBACK_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int PHASE_CYCLES = 8;
    localparam int DEAD_CYCLES = 1;
    localparam int TEMP_REF_C = 25;

    typedef enum logic [1:0] {
        MODE_STANDBY,
        MODE_STARTUP,
        MODE_NORMAL,
        MODE_POWER_SAVE
    } pmg_mode_t;

endpackage : pmg_pkg

// *** hw/pmg_power_ctrl.sv ***
/*
 pmg_power_ctrl: operating mode sequencer and charge pump gain control.
 Assumes decoded register accesses on the reg_* ports and analog status
 inputs that are synchronous to clk.
*/
`timescale 1ns/10ps
module pmg_power_ctrl #(
    parameter int STARTUP_CYCLES = pmg_pkg::STARTUP_CYCLES,
    parameter int IDLE_FALLBACK_CYCLES = pmg_pkg::IDLE_FALLBACK_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic enable_pin,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic overheat_shutdown,
    input wire logic [8:0] led_active,
    input wire logic pwm_off_phase,
    input wire logic [5:0] pumped_outputs_saturated,
    input wire logic battery_sufficient,
    input wire logic signed [7:0] temp_celsius,
    output logic [7:0] reg_rdata,
    output pmg_pkg::pmg_mode_t mode,
    output logic analog_on,
    output logic pwm_circuit_off,
    output logic [1:0] pump_gain,
    output logic pump_output_pulldown,
    output logic pump_charge_phase,
    output logic pump_pump_phase,
    output logic temp_comp_on,
    output logic signed [14:0] temp_comp
);

    localparam int PHASE_PERIOD = 2 * (pmg_pkg::PHASE_CYCLES + pmg_pkg::DEAD_CYCLES);

    logic [7:0] device_ctrl_q;
    logic [7:0] temp_comp_cfg_q;
    logic [7:0] gain_hyst_q;
    logic [7:0] general_config_q;
    pmg_pkg::pmg_mode_t prev_mode_q;
    logic [15:0] startup_cnt_q;
    logic [22:0] idle_cnt_q;
    logic [1:0] auto_gain_q;
    logic [4:0] phase_cnt_q;
    logic soft_reset;
    logic wr_ok;
    logic run_req;
    logic led_any;
    logic startup_done;
    logic idle_expired;
    logic [1:0] gain_sel;
    logic auto_sel;
    logic headroom_raw;
    logic headroom_low_f;
    logic battery_ok_f;
    logic wake_event;
    logic signed [8:0] temp_delta;
    logic signed [14:0] comp_product;

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
        reg_hit = (addr == target);
    endfunction : reg_hit

    // ==========================================================
    // register writes
    assign soft_reset = reg_wr_en && reg_hit(reg_addr, pmg_pkg::ADDR_SOFT_RESET)
                        && (reg_wdata == pmg_pkg::SOFT_RESET_VALUE);
    // register writes other than the soft reset only work with the enable pin high; reads do not need it
    assign wr_ok = reg_wr_en && enable_pin;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            device_ctrl_q <= pmg_pkg::DEVICE_CTRL_RESET;
            temp_comp_cfg_q <= pmg_pkg::TEMP_COMP_RESET;
            gain_hyst_q <= pmg_pkg::GAIN_HYST_RESET;
            general_config_q <= pmg_pkg::GENERAL_CONFIG_RESET;
        end else if (clk_en) begin
            if (soft_reset) begin
                device_ctrl_q <= pmg_pkg::DEVICE_CTRL_RESET;
                temp_comp_cfg_q <= pmg_pkg::TEMP_COMP_RESET;
                gain_hyst_q <= pmg_pkg::GAIN_HYST_RESET;
                general_config_q <= pmg_pkg::GENERAL_CONFIG_RESET;
            end else if (wr_ok) begin
                if (reg_hit(reg_addr, pmg_pkg::ADDR_DEVICE_CTRL)) begin
                    device_ctrl_q <= reg_wdata;
                end
                if (reg_hit(reg_addr, pmg_pkg::ADDR_TEMP_COMP)) begin
                    temp_comp_cfg_q <= reg_wdata;
                end
                if (reg_hit(reg_addr, pmg_pkg::ADDR_GAIN_HYST)) begin
                    gain_hyst_q <= reg_wdata;
                end
                if (reg_hit(reg_addr, pmg_pkg::ADDR_GENERAL_CONFIG)) begin
                    general_config_q <= reg_wdata;
                end
            end
        end
    end

    // ==========================================================
    // register reads
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            if (reg_rd_en) begin
                case (reg_addr)
                    pmg_pkg::ADDR_DEVICE_CTRL: reg_rdata <= device_ctrl_q;
                    pmg_pkg::ADDR_TEMP_COMP: reg_rdata <= temp_comp_cfg_q;
                    pmg_pkg::ADDR_GAIN_HYST: reg_rdata <= gain_hyst_q;
                    pmg_pkg::ADDR_GENERAL_CONFIG: reg_rdata <= general_config_q;
                    pmg_pkg::ADDR_STATUS: reg_rdata <= {4'h0, pump_gain, mode};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ==========================================================
    // mode sequencer
    assign run_req = device_ctrl_q[pmg_pkg::DEVICE_ON_BIT] && enable_pin;
    assign led_any = |led_active;
    assign startup_done = (startup_cnt_q >= 16'(STARTUP_CYCLES - 1));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode <= pmg_pkg::MODE_STANDBY;
            startup_cnt_q <= 16'h0000;
        end else if (clk_en) begin
            // reset beats off, off beats startup, startup beats idle and run
            if (soft_reset) begin
                mode <= pmg_pkg::MODE_STANDBY;
                startup_cnt_q <= 16'h0000;
            end else if (!run_req) begin
                mode <= pmg_pkg::MODE_STANDBY;
                startup_cnt_q <= 16'h0000;
            end else begin
                case (mode)
                    pmg_pkg::MODE_STANDBY: begin
                        mode <= pmg_pkg::MODE_STARTUP;
                        startup_cnt_q <= 16'h0000;
                    end
                    pmg_pkg::MODE_STARTUP: begin
                        if (!startup_done) begin
                            startup_cnt_q <= startup_cnt_q + 16'h0001;
                        end else if (!overheat_shutdown) begin
                            mode <= led_any ? pmg_pkg::MODE_NORMAL : pmg_pkg::MODE_POWER_SAVE;
                        end
                    end
                    pmg_pkg::MODE_NORMAL: begin
                        if (overheat_shutdown) begin
                            mode <= pmg_pkg::MODE_STARTUP;
                        end else if (!led_any) begin
                            mode <= pmg_pkg::MODE_POWER_SAVE;
                        end
                    end
                    pmg_pkg::MODE_POWER_SAVE: begin
                        if (overheat_shutdown) begin
                            mode <= pmg_pkg::MODE_STARTUP;
                        end else if (led_any) begin
                            mode <= pmg_pkg::MODE_NORMAL;
                        end
                    end
                    default: begin
                        mode <= pmg_pkg::MODE_STANDBY;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prev_mode_q <= pmg_pkg::MODE_STANDBY;
        end else if (clk_en) begin
            prev_mode_q <= mode;
        end
    end

    // ==========================================================
    // analog enables and pwm power save
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            analog_on <= 1'b0;
            pwm_circuit_off <= 1'b0;
        end else if (clk_en) begin
            analog_on <= (mode == pmg_pkg::MODE_STARTUP) || (mode == pmg_pkg::MODE_NORMAL);
            pwm_circuit_off <= (mode == pmg_pkg::MODE_NORMAL) && general_config_q[pmg_pkg::PWM_PS_BIT]
                               && pwm_off_phase;
        end
    end

    // ==========================================================
    // automatic gain decision
    assign gain_sel = general_config_q[pmg_pkg::GAIN_SEL_LSB +: 2];
    assign auto_sel = (gain_sel == pmg_pkg::GSEL_AUTO);
    // battery-fed outputs are not part of the headroom check
    assign headroom_raw = |pumped_outputs_saturated;
    assign idle_expired = (idle_cnt_q > 23'(IDLE_FALLBACK_CYCLES));

    pmg_gain_filter u_headroom_filter (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .clear(!auto_sel),
        .raw(headroom_raw),
        .hold_cycles(gain_hyst_q),
        .filtered(headroom_low_f)
    );

    pmg_gain_filter u_battery_filter (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .clear(!auto_sel),
        .raw(battery_sufficient),
        .hold_cycles(gain_hyst_q),
        .filtered(battery_ok_f)
    );

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            idle_cnt_q <= 23'h000000;
        end else if (clk_en) begin
            if (led_any || soft_reset) begin
                idle_cnt_q <= 23'h000000;
            end else if (!idle_expired) begin
                idle_cnt_q <= idle_cnt_q + 23'h000001;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            auto_gain_q <= pmg_pkg::PUMP_1X;
        end else if (clk_en) begin
            if (!auto_sel || soft_reset) begin
                auto_gain_q <= pmg_pkg::PUMP_1X;
            end else if (idle_expired) begin
                auto_gain_q <= pmg_pkg::PUMP_1X;
            end else if (headroom_low_f) begin
                auto_gain_q <= pmg_pkg::PUMP_1P5X;
            end else if (battery_ok_f) begin
                auto_gain_q <= pmg_pkg::PUMP_1X;
            end
        end
    end

    // ==========================================================
    // pump gain output
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pump_gain <= pmg_pkg::PUMP_OFF;
            pump_output_pulldown <= 1'b1;
        end else if (clk_en) begin
            pump_output_pulldown <= (gain_sel == pmg_pkg::GSEL_OFF);
            if (mode != pmg_pkg::MODE_NORMAL) begin
                pump_gain <= pmg_pkg::PUMP_OFF;
            end else begin
                case (gain_sel)
                    pmg_pkg::GSEL_OFF: pump_gain <= pmg_pkg::PUMP_OFF;
                    pmg_pkg::GSEL_BYPASS: pump_gain <= pmg_pkg::PUMP_1X;
                    pmg_pkg::GSEL_BOOST: pump_gain <= pmg_pkg::PUMP_1P5X;
                    default: pump_gain <= auto_gain_q;
                endcase
            end
        end
    end

    // ==========================================================
    // two-phase non-overlapping pump clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_cnt_q <= 5'h00;
            pump_charge_phase <= 1'b0;
            pump_pump_phase <= 1'b0;
        end else if (clk_en) begin
            if (pump_gain != pmg_pkg::PUMP_1P5X) begin
                phase_cnt_q <= 5'h00;
                pump_charge_phase <= 1'b0;
                pump_pump_phase <= 1'b0;
            end else begin
                if (phase_cnt_q == 5'(PHASE_PERIOD - 1)) begin
                    phase_cnt_q <= 5'h00;
                end else begin
                    phase_cnt_q <= phase_cnt_q + 5'h01;
                end
                // dead cycles between phases keep them from overlapping
                pump_charge_phase <= (phase_cnt_q < 5'(pmg_pkg::PHASE_CYCLES));
                pump_pump_phase <= (phase_cnt_q >= 5'(pmg_pkg::PHASE_CYCLES + pmg_pkg::DEAD_CYCLES))
                                   && (phase_cnt_q < 5'(2 * pmg_pkg::PHASE_CYCLES + pmg_pkg::DEAD_CYCLES));
            end
        end
    end

    // ==========================================================
    // temperature compensation
    assign wake_event = (prev_mode_q == pmg_pkg::MODE_POWER_SAVE) && (mode == pmg_pkg::MODE_NORMAL);
    assign temp_delta = $signed({temp_celsius[7], temp_celsius}) - 9'(pmg_pkg::TEMP_REF_C);
    assign comp_product = 15'($signed({1'b0, temp_comp_cfg_q[4:0]}) * temp_delta);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            temp_comp_on <= 1'b0;
            temp_comp <= 15'sh0000;
        end else if (clk_en) begin
            temp_comp_on <= (temp_comp_cfg_q[4:0] != 5'h00);
            if (temp_comp_cfg_q[4:0] == 5'h00) begin
                temp_comp <= 15'sh0000;
            end else if (mode == pmg_pkg::MODE_NORMAL
                         && (!temp_comp_cfg_q[pmg_pkg::TC_MODE_BIT] || wake_event)) begin
                temp_comp <= comp_product;
            end
        end
    end

endmodule : pmg_power_ctrl

// *** tb/pmg_host_model.sv ***
/*
 pmg_host_model: host driving the enable pin and register accesses.
 Assumes requests are taken on the rising clk edge.
*/
`timescale 1ns/10ps
module pmg_host_model #(
    parameter int ENABLE_WAIT = 20
) (
    input wire logic clk,
    output logic enable_pin,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        enable_pin = 1'b0;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // ==========
    // bus tasks
    task automatic power_on();
        @(posedge clk);
        enable_pin <= 1'b1;
        repeat (ENABLE_WAIT) @(posedge clk);
    endtask : power_on

    // released lines show the inverse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd
endmodule : pmg_host_model

// *** tb/pmg_power_ctrl_assertions.sv ***
/*
 pmg_power_ctrl_checker: concurrent checks on the controller ports.
 Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/10ps
module pmg_power_ctrl_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic enable_pin,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic overheat_shutdown,
    input wire logic [8:0] led_active,
    input wire logic pwm_off_phase,
    input wire logic [7:0] reg_rdata,
    input wire pmg_pkg::pmg_mode_t mode,
    input wire logic analog_on,
    input wire logic pwm_circuit_off,
    input wire logic [1:0] pump_gain,
    input wire logic pump_output_pulldown,
    input wire logic pump_charge_phase,
    input wire logic pump_pump_phase
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // no register write and not frozen
    wire logic go = clk_en && !reg_wr_en;

    // ==========
    // sequences
    sequence s_charge_end;
        pump_charge_phase ##1 !pump_charge_phase;
    endsequence
    sequence s_normal_idle;
        mode == pmg_pkg::MODE_NORMAL && led_active == 9'h000 && !overheat_shutdown && go;
    endsequence

    // ==========
    // assertions
    a_standby_when_off: assert property (clk_en && !enable_pin |=> mode == pmg_pkg::MODE_STANDBY)
        else $error("not standby");
    a_idle_power_save: assert property (s_normal_idle |=> mode inside {pmg_pkg::MODE_POWER_SAVE, pmg_pkg::MODE_STANDBY})
        else $error("no power save");
    a_overheat_hold: assert property (overheat_shutdown && clk_en && mode != pmg_pkg::MODE_STANDBY
        |=> mode inside {pmg_pkg::MODE_STARTUP, pmg_pkg::MODE_STANDBY}) else $error("overheat not held");
    a_analog_run: assert property (mode inside {pmg_pkg::MODE_STARTUP, pmg_pkg::MODE_NORMAL} && go |=> analog_on)
        else $error("analog off");
    a_analog_idle: assert property (mode inside {pmg_pkg::MODE_STANDBY, pmg_pkg::MODE_POWER_SAVE} && go |=> !analog_on)
        else $error("analog on");
    a_gain_in_normal: assert property (pump_gain != pmg_pkg::PUMP_OFF |-> $past(mode) == pmg_pkg::MODE_NORMAL)
        else $error("pump gain outside normal");
    a_pulldown_no_gain: assert property (pump_output_pulldown |-> pump_gain == pmg_pkg::PUMP_OFF)
        else $error("pump runs with pulldown");
    a_pwm_cut_cause: assert property (pwm_circuit_off |-> $past(pwm_off_phase) && $past(mode) == pmg_pkg::MODE_NORMAL)
        else $error("pwm cut without cause");
    a_phase_exclusive: assert property (!(pump_charge_phase && pump_pump_phase))
        else $error("pump phases overlap");
    a_dead_after_charge: assert property (s_charge_end |-> !pump_pump_phase)
        else $error("no dead cycle");
    a_status_read: assert property (reg_rd_en && clk_en && reg_addr == pmg_pkg::ADDR_STATUS
        |=> reg_rdata == {4'h0, $past(pump_gain), $past(mode)}) else $error("status read wrong");
endmodule : pmg_power_ctrl_checker

bind pmg_power_ctrl pmg_power_ctrl_checker chk (
    .clk(clk), .reset(reset), .clk_en(clk_en), .enable_pin(enable_pin), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .overheat_shutdown(overheat_shutdown),
    .led_active(led_active), .pwm_off_phase(pwm_off_phase), .reg_rdata(reg_rdata), .mode(mode),
    .analog_on(analog_on), .pwm_circuit_off(pwm_circuit_off), .pump_gain(pump_gain),
    .pump_output_pulldown(pump_output_pulldown), .pump_charge_phase(pump_charge_phase),
    .pump_pump_phase(pump_pump_phase)
);

// *** tb/test_pmg_power_ctrl.sv ***
/*
 test_pmg_power_ctrl: self-checking bench for the power controller.
 Assumes short startup and fallback counts and the host model.
*/
`timescale 1ns/10ps
module test_pmg_power_ctrl;
    localparam int SC = 20;
    localparam logic [1:0] GEXP [3] = '{pmg_pkg::PUMP_OFF, pmg_pkg::PUMP_1X, pmg_pkg::PUMP_1P5X};
    logic clk, reset, clk_en, enable_pin, reg_wr_en, reg_rd_en, ovh, pwm_off, batt_ok;
    logic analog_on, pwm_circuit_off, pump_output_pulldown, chg, pmp, temp_comp_on;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic [8:0] led;
    logic [5:0] sat;
    logic [1:0] pump_gain;
    logic signed [7:0] temp;
    logic signed [14:0] temp_comp;
    pmg_pkg::pmg_mode_t mode;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;

    pmg_host_model #(.ENABLE_WAIT(SC)) host (.clk(clk), .enable_pin(enable_pin), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    pmg_power_ctrl #(.STARTUP_CYCLES(SC), .IDLE_FALLBACK_CYCLES(30)) uut (
        .clk(clk), .reset(reset), .clk_en(clk_en), .enable_pin(enable_pin), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .overheat_shutdown(ovh),
        .led_active(led), .pwm_off_phase(pwm_off), .pumped_outputs_saturated(sat),
        .battery_sufficient(batt_ok), .temp_celsius(temp), .reg_rdata(reg_rdata), .mode(mode),
        .analog_on(analog_on), .pwm_circuit_off(pwm_circuit_off), .pump_gain(pump_gain),
        .pump_output_pulldown(pump_output_pulldown), .pump_charge_phase(chg), .pump_pump_phase(pmp),
        .temp_comp_on(temp_comp_on), .temp_comp(temp_comp));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========
    // helpers
    task automatic results();
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            results();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic wait_mode(input pmg_pkg::pmg_mode_t m, input int n);
        for (int i = 0; i < n && mode !== m; i++) step(1);
        check("mode", 16'(mode), 16'(m));
    endtask : wait_mode

    // ==========
    // scenarios
    task automatic t_reset_values();
        wait_mode(pmg_pkg::MODE_STANDBY, 0);
        check("pulldown", 16'(pump_output_pulldown), 16'h0001);
        host.rd(pmg_pkg::ADDR_DEVICE_CTRL, rd);
        check("ctrl", 16'(rd), 16'(pmg_pkg::DEVICE_CTRL_RESET));
        host.rd(pmg_pkg::ADDR_GAIN_HYST, rd);
        check("hyst", 16'(rd), 16'(pmg_pkg::GAIN_HYST_RESET));
        host.rd(8'h55, rd);
        check("unmapped", 16'(rd), 16'h0000);
        host.rd(pmg_pkg::ADDR_SOFT_RESET, rd);
        check("reset reg", 16'(rd), 16'h0000);
    endtask : t_reset_values

    task automatic t_enable_low();
        host.wr(pmg_pkg::ADDR_DEVICE_CTRL, 8'h40);
        step(3);
        wait_mode(pmg_pkg::MODE_STANDBY, 0);
        host.rd(pmg_pkg::ADDR_DEVICE_CTRL, rd);
        check("ctrl", 16'(rd), 16'h0000);
    endtask : t_enable_low

    task automatic t_startup();
        host.power_on();
        host.wr(pmg_pkg::ADDR_GENERAL_CONFIG, 8'h08);
        host.wr(pmg_pkg::ADDR_TEMP_COMP, 8'h03);
        led <= 9'h001;
        host.wr(pmg_pkg::ADDR_DEVICE_CTRL, 8'h40);
        wait_mode(pmg_pkg::MODE_STARTUP, 3);
        step(SC - 4);
        wait_mode(pmg_pkg::MODE_STARTUP, 0);
        wait_mode(pmg_pkg::MODE_NORMAL, 8);
        step(2);
        check("analog", 16'(analog_on), 16'h0001);
        check("gain", 16'(pump_gain), 16'(pmg_pkg::PUMP_1X));
        check("tc", 16'(temp_comp), 16'd30);
        check("tc on", 16'(temp_comp_on), 16'h0001);
    endtask : t_startup

    task automatic t_power_save();
        @(posedge clk);
        led <= 9'h000;
        wait_mode(pmg_pkg::MODE_POWER_SAVE, 4);
        step(2);
        check("analog", 16'(analog_on), 16'h0000);
        check("gain", 16'(pump_gain), 16'(pmg_pkg::PUMP_OFF));
        @(posedge clk) led <= 9'h100;
        wait_mode(pmg_pkg::MODE_NORMAL, 4);
    endtask : t_power_save

    task automatic t_overheat();
        @(posedge clk);
        ovh <= 1'b1;
        wait_mode(pmg_pkg::MODE_STARTUP, 4);
        step(3 * SC);
        wait_mode(pmg_pkg::MODE_STARTUP, 0);
        @(posedge clk) ovh <= 1'b0;
        wait_mode(pmg_pkg::MODE_NORMAL, 4);
    endtask : t_overheat

    task automatic t_gain();
        int nc = 0;
        int np = 0;
        for (int g = 0; g < 3; g++) begin
            host.wr(pmg_pkg::ADDR_GENERAL_CONFIG, 8'(g << pmg_pkg::GAIN_SEL_LSB));
            step(3);
            check("gain", 16'(pump_gain), 16'(GEXP[g]));
            check("pulldown", 16'(pump_output_pulldown), 16'(g == 0));
        end
        repeat (36) begin
            step(1);
            nc += int'(chg === 1'b1);
            np += int'(pmp === 1'b1);
        end
        check("charge", 16'(nc), 16'd16);
        check("pump", 16'(np), 16'd16);
        host.wr(pmg_pkg::ADDR_GAIN_HYST, 8'h02);
        batt_ok <= 1'b1;
        host.wr(pmg_pkg::ADDR_GENERAL_CONFIG, 8'h18);
        step(12);
        check("auto", 16'(pump_gain), 16'(pmg_pkg::PUMP_1X));
        @(posedge clk) sat <= 6'h20;
        step(2);
        check("auto", 16'(pump_gain), 16'(pmg_pkg::PUMP_1X));
        step(12);
        check("auto", 16'(pump_gain), 16'(pmg_pkg::PUMP_1P5X));
        @(posedge clk) led <= 9'h000;
        step(40);
        @(posedge clk) led <= 9'h100;
        step(2);
        check("fallback", 16'(pump_gain), 16'(pmg_pkg::PUMP_1X));
        @(posedge clk) sat <= 6'h00;
        step(12);
        check("auto", 16'(pump_gain), 16'(pmg_pkg::PUMP_1X));
    endtask : t_gain

    task automatic t_pwm_save();
        host.wr(pmg_pkg::ADDR_GENERAL_CONFIG, 8'h20);
        pwm_off <= 1'b1;
        step(3);
        check("pwm cut", 16'(pwm_circuit_off), 16'h0001);
        @(posedge clk) pwm_off <= 1'b0;
        step(3);
        check("pwm cut", 16'(pwm_circuit_off), 16'h0000);
        host.rd(pmg_pkg::ADDR_STATUS, rd);
        check("status", 16'(rd), {10'h0, pmg_pkg::PUMP_OFF, 2'(pmg_pkg::MODE_NORMAL)});
    endtask : t_pwm_save

    task automatic t_soft_reset();
        host.wr(pmg_pkg::ADDR_SOFT_RESET, pmg_pkg::SOFT_RESET_VALUE);
        step(1);
        wait_mode(pmg_pkg::MODE_STANDBY, 0);
        host.rd(pmg_pkg::ADDR_GENERAL_CONFIG, rd);
        check("config", 16'(rd), 16'(pmg_pkg::GENERAL_CONFIG_RESET));
        host.rd(pmg_pkg::ADDR_GAIN_HYST, rd);
        check("hyst", 16'(rd), 16'(pmg_pkg::GAIN_HYST_RESET));
        step(SC + 5);
        wait_mode(pmg_pkg::MODE_STANDBY, 0);
        check("pulldown", 16'(pump_output_pulldown), 16'h0001);
    endtask : t_soft_reset

    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        ovh = 1'b0;
        pwm_off = 1'b0;
        batt_ok = 1'b0;
        led = 9'h000;
        sat = 6'h00;
        temp = 8'sd35;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        step(1);
        t_reset_values();
        t_enable_low();
        t_startup();
        t_power_save();
        t_overheat();
        t_gain();
        t_pwm_save();
        t_soft_reset();
        results();
    end
endmodule : test_pmg_power_ctrl
